// ==== design/wdog_top.sv ====
// Windowed watchdog with APB register access and MCU reset request.
// ----------------------------------------------------------------
// What this block does
// - Window writes take effect only while the control key field holds the unlock value; control enable and divider also when the write carries it.
// - Service register writes take effect whatever the key holds.
// - The count clock is the 32 kHz source divided by 2, 16, 128 or 1024 per a 2-bit field.
// - Control bit 0 enables the watchdog and resets to 0.
// - The 8-bit countdown value is readable in a read-only register that resets to 0.
// - Enabling or servicing loads the counter from the reload value, which resets to 0xff.
// - Writing the service code reloads and restarts the count, then the register self-clears.
// - Reaching zero unserviced raises an MCU reset and clears the enable.
// - Servicing while the counter is at or above the window raises an MCU reset and disables.
// - The 8-bit window register is read-write and resets to 0xff.
// ----------------------------------------------------------------
`timescale 1ns/10ps
module wdog_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        src_32k,
    output logic             mcu_reset_request_n
);

    wdog_pkg::wdog_ctl_t ctl_r;
    logic [7:0]          countdown_value_r;
    logic [7:0]          reload_value_r;
    logic [7:0]          window_r;
    logic [7:0]          service_r;
    logic                tick;
    logic                acc;
    logic                wr;
    logic                unlocked;
    logic                svc_hit;
    logic                early;
    logic                expire;
    logic                fault;
    logic                en_set;
    logic                mapped;
    logic [7:0]          rd_val;
    wdog_pkg::wdog_ctl_t ctl_wr;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ----------------------------------------------------------------
    // APB slave, one wait state
    // ----------------------------------------------------------------
    assign acc = psel & penable;
    assign wr  = acc & pready & pwrite;

    always_comb
    begin
        mapped = 1'b1;
        rd_val = 8'h00;
        if (paddr == wdog_pkg::CTL_ADDR)
            rd_val = ctl_r;
        else if (paddr == wdog_pkg::CNT_ADDR)
            rd_val = countdown_value_r;
        else if (paddr == wdog_pkg::RELOAD_ADDR)
            rd_val = reload_value_r;
        else if (paddr == wdog_pkg::WIN_ADDR)
            rd_val = window_r;
        else if (paddr == wdog_pkg::SVC_ADDR)
            rd_val = service_r;
        else
            mapped = 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= acc & ~pready;
            pslverr <= acc & ~pready & ~mapped;
            if (acc && !pready && !pwrite)
                prdata <= {24'h00_0000, rd_val};
            else
                prdata <= 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // Control, window and reload registers
    // ----------------------------------------------------------------
    assign ctl_wr   = pwdata[7:0];
    assign unlocked = (ctl_r.key == wdog_pkg::KEY_UNLOCK);
    assign en_set   = wr && paddr == wdog_pkg::CTL_ADDR && ctl_wr.en && !ctl_r.en
                      && (unlocked || ctl_wr.key == wdog_pkg::KEY_UNLOCK);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctl_r <= wdog_pkg::CTL_RESET;
        end
        else
        begin
            if (wr && paddr == wdog_pkg::CTL_ADDR)
            begin
                ctl_r.key <= ctl_wr.key;
                if (unlocked || ctl_wr.key == wdog_pkg::KEY_UNLOCK)
                begin
                    ctl_r.count_clock_divider <= ctl_wr.count_clock_divider;
                    ctl_r.en                  <= ctl_wr.en;
                end
            end
            if (fault)
                ctl_r.en <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            window_r       <= wdog_pkg::WIN_RESET;
            reload_value_r <= wdog_pkg::RELOAD_RESET;
        end
        else if (wr && paddr == wdog_pkg::WIN_ADDR && unlocked)
        begin
            window_r <= pwdata[7:0];
        end
    end

    // ----------------------------------------------------------------
    // Service register and fault detection
    // ----------------------------------------------------------------
    assign svc_hit = wr && paddr == wdog_pkg::SVC_ADDR
                     && pwdata[7:0] == wdog_pkg::SERVICE_CODE;
    assign early   = svc_hit && ctl_r.en && countdown_value_r >= window_r;
    assign expire  = ctl_r.en && countdown_value_r == 8'h00;
    assign fault   = early | expire;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            service_r <= wdog_pkg::SVC_RESET;
        else if (wr && paddr == wdog_pkg::SVC_ADDR)
            service_r <= pwdata[7:0];
        else
            service_r <= wdog_pkg::SVC_RESET;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mcu_reset_request_n <= 1'b1;
        else
            mcu_reset_request_n <= ~fault;
    end

    // ----------------------------------------------------------------
    // Countdown
    // ----------------------------------------------------------------
    wdog_tick_gen u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .src_32k (src_32k),
        .div_sel (ctl_r.count_clock_divider),
        .run     (ctl_r.en),
        .tick    (tick)
    );

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            countdown_value_r <= wdog_pkg::CNT_RESET;
        else if (en_set)
            countdown_value_r <= reload_value_r;
        else if (svc_hit && ctl_r.en && !fault)
            countdown_value_r <= reload_value_r;
        else if (tick && ctl_r.en && countdown_value_r != 8'h00)
            countdown_value_r <= countdown_value_r - 8'h01;
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_locked_window;
        wr && paddr == wdog_pkg::WIN_ADDR && !unlocked |=> $stable(window_r);
    endproperty
    a_locked_window: assert property (p_locked_window)
        else $error("Window changed while locked.");

    property p_service_any_key;
        svc_hit && ctl_r.en && countdown_value_r < window_r && countdown_value_r != 8'h00
        |=> countdown_value_r == reload_value_r && ctl_r.en && mcu_reset_request_n;
    endproperty
    a_service_any_key: assert property (p_service_any_key)
        else $error("Valid service did not reload the counter.");

    property p_enable_loads;
        en_set |=> ctl_r.en && countdown_value_r == $past(reload_value_r);
    endproperty
    a_enable_loads: assert property (p_enable_loads)
        else $error("Enable did not load the reload value.");

    property p_service_clears;
        service_r != 8'h00 |=> service_r == 8'h00 || $past(wr);
    endproperty
    a_service_clears: assert property (p_service_clears)
        else $error("Service register did not self-clear.");

    property p_expire;
        ctl_r.en && countdown_value_r == 8'h00 |=> !mcu_reset_request_n && !ctl_r.en;
    endproperty
    a_expire: assert property (p_expire)
        else $error("Zero count did not raise reset and disable.");

    property p_early;
        svc_hit && ctl_r.en && countdown_value_r >= window_r
        |=> !mcu_reset_request_n && !ctl_r.en;
    endproperty
    a_early: assert property (p_early)
        else $error("Early service did not raise reset.");

    property p_hold_no_tick;
        !tick && !en_set && !svc_hit |=> $stable(countdown_value_r);
    endproperty
    a_hold_no_tick: assert property (p_hold_no_tick)
        else $error("Counter moved without a tick.");

    property p_step_one;
        tick && ctl_r.en && countdown_value_r != 8'h00 && !en_set && !svc_hit
        |=> countdown_value_r == $past(countdown_value_r) - 8'h01;
    endproperty
    a_step_one: assert property (p_step_one)
        else $error("Counter did not drop by one.");

    property p_reset_pulse;
        !mcu_reset_request_n |-> $past(fault);
    endproperty
    a_reset_pulse: assert property (p_reset_pulse)
        else $error("Reset request without a fault.");

    property p_disabled_count_still;
        !ctl_r.en && !en_set |=> $stable(countdown_value_r);
    endproperty
    a_disabled_count_still: assert property (p_disabled_count_still)
        else $error("Counter moved while disabled.");

    property p_fault_pulse;
        fault |=> !mcu_reset_request_n;
    endproperty
    a_fault_pulse: assert property (p_fault_pulse)
        else $error("Fault did not pull the reset request low.");

    property p_pulse_ends;
        !mcu_reset_request_n |=> mcu_reset_request_n;
    endproperty
    a_pulse_ends: assert property (p_pulse_ends)
        else $error("Reset request stayed low.");

    property p_ctl_locked;
        wr && paddr == wdog_pkg::CTL_ADDR && !unlocked && ctl_wr.key != wdog_pkg::KEY_UNLOCK
        && !fault |=> $stable(ctl_r.en) && $stable(ctl_r.count_clock_divider);
    endproperty
    a_ctl_locked: assert property (p_ctl_locked)
        else $error("Control changed while locked.");

    property p_key_written;
        wr && paddr == wdog_pkg::CTL_ADDR |=> ctl_r.key == $past(ctl_wr.key);
    endproperty
    a_key_written: assert property (p_key_written)
        else $error("Key field did not take the written value.");

    property p_counter_ro;
        wr && paddr == wdog_pkg::CNT_ADDR && !tick |=> $stable(countdown_value_r);
    endproperty
    a_counter_ro: assert property (p_counter_ro)
        else $error("Counter register took a bus write.");

    property p_window_write;
        wr && paddr == wdog_pkg::WIN_ADDR && unlocked |=> window_r == $past(pwdata[7:0]);
    endproperty
    a_window_write: assert property (p_window_write)
        else $error("Unlocked window write was lost.");

    property p_rd_counter;
        acc && !pready && !pwrite && paddr == wdog_pkg::CNT_ADDR
        |=> prdata[7:0] == $past(countdown_value_r);
    endproperty
    a_rd_counter: assert property (p_rd_counter)
        else $error("Counter read returned a stale value.");

    c_enable: cover property (en_set);
    c_service_ok: cover property (svc_hit && ctl_r.en && countdown_value_r < window_r
                                  && countdown_value_r != 8'h00);
    c_early: cover property (early);
    c_expire: cover property (expire);
    c_locked_service: cover property (svc_hit && !unlocked && ctl_r.en);

endmodule

// ==== design/wdog_pkg.sv ====
// Package with register map, field layout and constants of the windowed watchdog.
package wdog_pkg;

    // ----------------------------------------------------------------
    // Register indices and byte addresses
    // ----------------------------------------------------------------
    localparam logic [11:0] CTL_IDX    = 12'h050;
    localparam logic [11:0] CNT_IDX    = 12'h051;
    localparam logic [11:0] RELOAD_IDX = 12'h052;
    localparam logic [11:0] WIN_IDX    = 12'h053;
    localparam logic [11:0] SVC_IDX    = 12'h054;
    localparam logic [11:0] CTL_ADDR    = {CTL_IDX[9:0], 2'b00};
    localparam logic [11:0] CNT_ADDR    = {CNT_IDX[9:0], 2'b00};
    localparam logic [11:0] RELOAD_ADDR = {RELOAD_IDX[9:0], 2'b00};
    localparam logic [11:0] WIN_ADDR    = {WIN_IDX[9:0], 2'b00};
    localparam logic [11:0] SVC_ADDR    = {SVC_IDX[9:0], 2'b00};

    // ----------------------------------------------------------------
    // Field positions, codes and reset values
    // ----------------------------------------------------------------
    localparam int          KEY_LSB       = 3;
    localparam int          DIV_LSB       = 1;
    localparam int          EN_BIT        = 0;
    localparam logic [4:0]  KEY_UNLOCK    = 5'h14;
    localparam logic [7:0]  SERVICE_CODE  = 8'hac;
    localparam logic [7:0]  CTL_RESET     = 8'h00;
    localparam logic [7:0]  CNT_RESET     = 8'h00;
    localparam logic [7:0]  RELOAD_RESET  = 8'hff;
    localparam logic [7:0]  WIN_RESET     = 8'hff;
    localparam logic [7:0]  SVC_RESET     = 8'h00;

    // ----------------------------------------------------------------
    // Count clock divider, last prescale count for each selection
    // ----------------------------------------------------------------
    localparam logic [9:0]  DIV2_LAST     = 10'h001;
    localparam logic [9:0]  DIV16_LAST    = 10'h00f;
    localparam logic [9:0]  DIV128_LAST   = 10'h07f;
    localparam logic [9:0]  DIV1024_LAST  = 10'h3ff;

    typedef enum logic [1:0] {
        DIV_BY_2,
        DIV_BY_16,
        DIV_BY_128,
        DIV_BY_1024
    } wdog_div_t;

    typedef struct packed {
        logic [4:0] key;
        wdog_div_t  count_clock_divider;
        logic       en;
    } wdog_ctl_t;

endpackage

// ==== design/wdog_tick_gen.sv ====
// Count clock tick generator: synchronises the slow source and divides it.
`timescale 1ns/10ps
module wdog_tick_gen (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              src_32k,
    input  wdog_pkg::wdog_div_t    div_sel,
    input  wire logic              run,
    output logic                   tick
);

    logic [1:0] sync_r;
    logic       prev_r;
    logic [9:0] pre_r;
    logic [9:0] last;
    logic       src_rise;

    // ----------------------------------------------------------------
    // Synchroniser and edge detect
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync_r <= 2'b00;
            prev_r <= 1'b0;
        end
        else
        begin
            sync_r <= {sync_r[0], src_32k};
            prev_r <= sync_r[1];
        end
    end

    assign src_rise = sync_r[1] & ~prev_r;

    // ----------------------------------------------------------------
    // Divider
    // ----------------------------------------------------------------
    always_comb
    begin
        case (div_sel)
            wdog_pkg::DIV_BY_2:   last = wdog_pkg::DIV2_LAST;
            wdog_pkg::DIV_BY_16:  last = wdog_pkg::DIV16_LAST;
            wdog_pkg::DIV_BY_128: last = wdog_pkg::DIV128_LAST;
            default:              last = wdog_pkg::DIV1024_LAST;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pre_r <= 10'h000;
            tick  <= 1'b0;
        end
        else if (!run)
        begin
            pre_r <= 10'h000;
            tick  <= 1'b0;
        end
        else
        begin
            tick <= 1'b0;
            if (src_rise)
            begin
                if (pre_r >= last)
                begin
                    pre_r <= 10'h000;
                    tick  <= 1'b1;
                end
                else
                begin
                    pre_r <= pre_r + 10'h001;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_pre_bound;
        @(posedge pclk) disable iff (!presetn)
        run && $past(run) && $stable(div_sel) && $past(pre_r) <= $past(last)
        |-> pre_r <= last;
    endproperty
    a_pre_bound: assert property (p_pre_bound)
        else $error("Prescaler passed its selected limit.");

    property p_tick_needs_edge;
        @(posedge pclk) disable iff (!presetn)
        $rose(tick) |-> $past(src_rise) && $past(run);
    endproperty
    a_tick_needs_edge: assert property (p_tick_needs_edge)
        else $error("Tick raised without a source edge.");

endmodule

// ==== verif/wdog_tb_top.sv ====
// Self-checking testbench of the windowed watchdog with APB register access.
`timescale 1ns/10ps
module wdog_tb_top;

    // ----------------------------------------------------------------
    // Signals, clock and source
    // ----------------------------------------------------------------
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        src_32k;
    logic        mcu_reset_request_n;
    logic        prev_n = 1'b1;
    logic [7:0]  rd;
    logic        err;
    logic [7:0]  w;
    logic [7:0]  v;
    int          num_errors;
    int          comparisons;
    int          cyc = 0;
    int          pulses = 0;
    int          low_cycles = 0;
    int          t0;
    int          dt;
    int          n;

    wdog_top dut (
        .pclk                (pclk),
        .presetn             (presetn),
        .psel                (psel),
        .penable             (penable),
        .pwrite              (pwrite),
        .paddr               (paddr),
        .pwdata              (pwdata),
        .prdata              (prdata),
        .pready              (pready),
        .pslverr             (pslverr),
        .src_32k             (src_32k),
        .mcu_reset_request_n (mcu_reset_request_n)
    );

    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    initial
    begin
        src_32k = 1'b0;
        forever
        begin
            repeat (4) @(posedge pclk);
            src_32k <= ~src_32k;
        end
    end

    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (mcu_reset_request_n === 1'b0)
            low_cycles <= low_cycles + 1;
        if (mcu_reset_request_n === 1'b0 && prev_n === 1'b1)
            pulses <= pulses + 1;
        prev_n <= mcu_reset_request_n;
    end

    // ----------------------------------------------------------------
    // Bus tasks, checks and expectations
    // ----------------------------------------------------------------
    task automatic conclude();
        if (num_errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr_en, input logic [11:0] a, input logic [7:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr_en;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rchk(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk(rd, e);
    endtask

    task automatic poll(input int mode, input logic [7:0] lim);
        bit hit;
        int k;
        hit = 1'b0;
        k = 0;
        while (!hit && k < 8000)
        begin
            apb(1'b0, wdog_pkg::CNT_ADDR, 8'h00);
            k++;
            hit = (mode == 0) ? (rd === lim) : (mode == 1) ? (rd < lim) : (rd !== lim);
        end
        chk({7'h00, hit}, 8'h01);
    endtask

    task automatic svc(input logic [7:0] d, input logic fault);
        int p0;
        int l0;
        p0 = pulses;
        l0 = low_cycles;
        wr(wdog_pkg::SVC_ADDR, d);
        repeat (3) @(posedge pclk);
        chk(8'(pulses - p0), {7'h00, fault});
        chk(8'(low_cycles - l0), {7'h00, fault});
    endtask

    function automatic int tick_cycles(input int sel);
        return 8 * (2 << (3 * sel));
    endfunction

    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        num_errors = 0;
        comparisons = 0;
        void'($urandom(32'h228e));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk(wdog_pkg::CTL_ADDR, wdog_pkg::CTL_RESET);
        rchk(wdog_pkg::CNT_ADDR, wdog_pkg::CNT_RESET);
        rchk(wdog_pkg::RELOAD_ADDR, wdog_pkg::RELOAD_RESET);
        rchk(wdog_pkg::WIN_ADDR, wdog_pkg::WIN_RESET);
        rchk(wdog_pkg::SVC_ADDR, wdog_pkg::SVC_RESET);
        apb(1'b0, 12'h158, 8'h00);
        chk({7'h00, err}, 8'h01);
        chk(rd, 8'h00);
        wr(wdog_pkg::WIN_ADDR, 8'h10);
        rchk(wdog_pkg::WIN_ADDR, wdog_pkg::WIN_RESET);
        wr(wdog_pkg::CTL_ADDR, 8'h01);
        rchk(wdog_pkg::CTL_ADDR, 8'h00);
        wr(wdog_pkg::CNT_ADDR, 8'h5a);
        rchk(wdog_pkg::CNT_ADDR, 8'h00);
        w = 8'h40 + 8'($urandom_range(127));
        wr(wdog_pkg::CTL_ADDR, {wdog_pkg::KEY_UNLOCK, 3'b000});
        wr(wdog_pkg::WIN_ADDR, w);
        rchk(wdog_pkg::WIN_ADDR, w);
        wr(wdog_pkg::RELOAD_ADDR, 8'h00);
        rchk(wdog_pkg::RELOAD_ADDR, wdog_pkg::RELOAD_RESET);
        for (int d = 3; d >= 0; d--)
        begin
            wr(wdog_pkg::CTL_ADDR, {wdog_pkg::KEY_UNLOCK, 3'b000});
            wr(wdog_pkg::CTL_ADDR, {wdog_pkg::KEY_UNLOCK, 2'(d), 1'b1});
            if (d == 3)
                rchk(wdog_pkg::CNT_ADDR, 8'hff);
            poll(0, 8'hfe);
            t0 = cyc;
            poll(2, 8'hfe);
            chk(rd, 8'hfd);
            dt = cyc - t0 - tick_cycles(d);
            chk(8'(dt >= -8 && dt <= 8), 8'h01);
        end
        wr(wdog_pkg::CTL_ADDR, {wdog_pkg::KEY_UNLOCK, 3'b001});
        wr(wdog_pkg::CTL_ADDR, {wdog_pkg::KEY_UNLOCK, 3'b001});
        repeat (4)
        begin
            v = 8'($urandom);
            if (v == wdog_pkg::SERVICE_CODE)
                v = 8'h00;
            svc(v, 1'b0);
        end
        svc(wdog_pkg::SERVICE_CODE, 1'b1);
        rchk(wdog_pkg::CTL_ADDR, {wdog_pkg::KEY_UNLOCK, 3'b000});
        wr(wdog_pkg::CTL_ADDR, {wdog_pkg::KEY_UNLOCK, 3'b001});
        poll(1, w);
        svc(wdog_pkg::SERVICE_CODE, 1'b0);
        apb(1'b0, wdog_pkg::CNT_ADDR, 8'h00);
        chk(8'(rd >= 8'hfe), 8'h01);
        rchk(wdog_pkg::SVC_ADDR, 8'h00);
        wr(wdog_pkg::CTL_ADDR, 8'h01);
        wr(wdog_pkg::WIN_ADDR, 8'h10);
        rchk(wdog_pkg::WIN_ADDR, w);
        wr(wdog_pkg::CTL_ADDR, 8'h00);
        rchk(wdog_pkg::CTL_ADDR, 8'h01);
        poll(1, w);
        svc(wdog_pkg::SERVICE_CODE, 1'b0);
        apb(1'b0, wdog_pkg::CNT_ADDR, 8'h00);
        chk(8'(rd >= 8'hfe), 8'h01);
        t0 = pulses;
        dt = low_cycles;
        n = 0;
        while (pulses == t0 && n < 6000)
        begin
            @(posedge pclk);
            n++;
        end
        repeat (3) @(posedge pclk);
        chk(8'(pulses - t0), 8'h01);
        chk(8'(low_cycles - dt), 8'h01);
        rchk(wdog_pkg::CTL_ADDR, 8'h00);
        rchk(wdog_pkg::CNT_ADDR, 8'h00);
        conclude();
    end

    initial
    begin
        repeat (90000) @(posedge pclk);
        num_errors++;
        conclude();
    end

endmodule
